// ### rtl/crg_core.sv
// register-group instruction core with byte memory port and fixed cycle timing
// Overview of operation
// - decrement_byte on memory decrements byte at HL, updates Z S P aux.
// - decrement_byte on a register decrements it, updates Z S P aux.
// - decrement_pair subtracts one from BC, DE, HL or stack_pointer.
// - increment_byte on memory increments byte at HL, updates Z S P aux.
// - increment_byte on a register increments it, updates Z S P aux.
// - increment_pair adds one to BC, DE, HL or stack_pointer.
// - direct_load_pair_hl reads L from address b3:b2, H from next address.
// - immediate_pair_load puts byte 3 in high half, byte 2 in low half.
// - immediate_byte_move to memory writes byte 2 at address HL.
// - immediate_byte_move to register loads it with byte 2.
// - byte_move register to memory writes register at address HL.
// - byte_move memory to register loads register from address HL.
// - byte_move between registers copies source, source stays unchanged.
// - direct_store_pair_hl writes L to address b3:b2, H to next address.
// - swap_hl_de swaps H with D and L with E at once.
// - swap_hl_stack_top swaps L and H with stack top bytes, pointer unchanged.
// - add with carry opcodes 88-8F take 4, memory 8E and immediate CE take 7.
// - plain add opcodes 80-87 take 4, memory 86 7, immediate C6.
// - and_accumulator A0-A7 take 4, memory 7, and_immediate E6 takes 7.
// - conditional call takes short count on failed condition, long when taken.
// - add, adc and and update carry, zero, sign, parity and aux flags.
module crg_core
  import crg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] mem_rdata,
  output logic [15:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  output logic instr_done,
  output logic [7:0] flags
);

  crg_alu_if alu_link ();
  crg_alu crg_alu_i (.alu_bus(alu_link));

  crg_state_t state_reg, state_next;
  logic [7:0] regs_reg [0:7];
  logic [7:0] regs_next [0:7];
  logic [7:0] flag_reg, flag_next;
  logic [15:0] pc_reg, pc_next;
  logic [15:0] sp_reg, sp_next;
  logic [7:0] op_reg, op_next;
  logic [7:0] b2_reg, b2_next;
  logic [7:0] b3_reg, b3_next;
  logic [7:0] tmp_reg, tmp_next;
  logic [7:0] tmp2_reg, tmp2_next;
  logic [1:0] fidx_reg, fidx_next;
  logic [1:0] len_reg, len_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [4:0] states_reg, states_next;
  logic [1:0] step_reg, step_next;
  logic [15:0] addr_reg, addr_next;
  logic rd_reg, rd_next;
  logic wr_reg, wr_next;
  logic [7:0] wdata_reg, wdata_next;
  logic done_reg, done_next;

  // opcode field decode
  wire logic [2:0] dst_w = op_reg[5:3];
  wire logic [2:0] src_w = op_reg[2:0];
  wire logic [1:0] rp_w = op_reg[5:4];
  wire logic is_incdec_b = (op_reg[7:6] == 2'b00) && (op_reg[2:1] == 2'b10);
  wire logic is_incdec_p = (op_reg[7:6] == 2'b00) && (op_reg[2:0] == 3'b011);
  wire logic is_pair_load = (op_reg[7:6] == 2'b00) && (op_reg[3:0] == 4'h1);
  wire logic is_mvi = (op_reg[7:6] == 2'b00) && (op_reg[2:0] == 3'b110);
  wire logic is_mov = (op_reg[7:6] == 2'b01) && (op_reg != CRG_OP_HALT_SLOT);
  wire logic is_alu_r = (op_reg[7:6] == 2'b10) &&
                        (dst_w == 3'h0 || dst_w == 3'h1 || dst_w == 3'h4);
  wire logic is_alu_i = (op_reg == CRG_OP_ADD_IMM) || (op_reg == CRG_OP_ADC_IMM) ||
                        (op_reg == CRG_OP_AND_IMM);
  wire logic is_load_hl = (op_reg == CRG_OP_LOAD_HL);
  wire logic is_store_hl = (op_reg == CRG_OP_STORE_HL);
  wire logic is_swap_stack = (op_reg == CRG_OP_SWAP_STACK);
  wire logic is_call = (op_reg == CRG_OP_CALL) ||
                       (op_reg == CRG_OP_CALL_CARRY && flag_reg[CRG_FLAG_CY]);
  wire logic dst_mem = (dst_w == CRG_REG_MEM);
  wire logic src_mem = (src_w == CRG_REG_MEM);

  // register pair views
  wire logic [15:0] hl_w = {regs_reg[CRG_REG_H], regs_reg[CRG_REG_L]};
  wire logic [15:0] direct_w = {b3_reg, b2_reg};
  wire logic [15:0] pair_w = (rp_w == CRG_PAIR_SP) ? sp_reg :
                             {regs_reg[{rp_w, 1'b0}], regs_reg[{rp_w, 1'b1}]};
  wire logic [15:0] pair_step_w = op_reg[3] ? (pair_w - 16'h0001) : (pair_w + 16'h0001);

  // memory step count per instruction
  wire logic [2:0] nsteps_w = (is_incdec_b && dst_mem) ? 3'h2 :
                              ((is_mvi && dst_mem) || (is_mov && (dst_mem || src_mem))) ? 3'h1 :
                              (is_alu_r && src_mem) ? 3'h1 :
                              (is_load_hl || is_store_hl || is_call) ? 3'h2 :
                              is_swap_stack ? 3'h4 : 3'h0;

  // per-step direction, address and write data
  wire logic [15:0] step_off = {15'h0000, step_reg[0]};
  wire logic step_wr = (is_incdec_b && step_reg == 2'h1) || (is_mvi && dst_mem) ||
                       (is_mov && dst_mem) || is_store_hl || is_call ||
                       (is_swap_stack && step_reg[1]);
  wire logic [15:0] step_addr = (is_load_hl || is_store_hl) ? (direct_w + step_off) :
                                is_swap_stack ? (sp_reg + step_off) :
                                is_call ? (sp_reg - 16'h0001 - step_off) : hl_w;
  wire logic [7:0] step_data = is_incdec_b ? alu_link.res :
                               is_mvi ? b2_reg :
                               is_mov ? regs_reg[src_w] :
                               is_call ? (step_reg[0] ? pc_reg[7:0] : pc_reg[15:8]) :
                               step_reg[0] ? regs_reg[CRG_REG_H] : regs_reg[CRG_REG_L];

  // alu operand selection
  assign alu_link.op = is_incdec_b ? (op_reg[0] ? CRG_ALU_DEC : CRG_ALU_INC) :
                       crg_alu_op_t'(dst_w);
  assign alu_link.a = is_incdec_b ? (dst_mem ? tmp_reg : regs_reg[dst_w]) :
                      regs_reg[CRG_REG_A];
  assign alu_link.b = is_alu_i ? b2_reg : (src_mem ? mem_rdata : regs_reg[src_w]);
  assign alu_link.cin = flag_reg[CRG_FLAG_CY];

  // cycle index inside the instruction; the opcode fetch cycle is index 0, so one
  // cycle after it the count reads 1 and the wait ends exactly on the documented total
  wire logic fetch_start = (state_reg == CRG_ST_FETCH) && (fidx_reg == 2'h0);
  wire logic [1:0] len_now = (fidx_reg == 2'h0) ? crg_instr_len(mem_rdata) : len_reg;
  assign cnt_next = fetch_start ? 5'h01 : (cnt_reg + 5'h01);

  // next-state logic
  always_comb begin
    state_next = state_reg;
    regs_next = regs_reg;
    flag_next = flag_reg;
    pc_next = pc_reg;
    sp_next = sp_reg;
    op_next = op_reg;
    b2_next = b2_reg;
    b3_next = b3_reg;
    tmp_next = tmp_reg;
    tmp2_next = tmp2_reg;
    fidx_next = fidx_reg;
    len_next = len_reg;
    states_next = states_reg;
    step_next = step_reg;
    addr_next = addr_reg;
    rd_next = 1'b0;
    wr_next = 1'b0;
    wdata_next = wdata_reg;
    done_next = 1'b0;
    case (state_reg)
      CRG_ST_FETCH: begin
        addr_next = pc_reg;
        rd_next = 1'b1;
        pc_next = pc_reg + 16'h0001;
        state_next = CRG_ST_FCAP;
      end
      CRG_ST_FCAP: begin
        if (fidx_reg == 2'h0) begin
          op_next = mem_rdata;
          len_next = len_now;
          states_next = crg_instr_states(mem_rdata, flag_reg[CRG_FLAG_CY]);
        end
        if (fidx_reg == 2'h1) b2_next = mem_rdata;
        if (fidx_reg == 2'h2) b3_next = mem_rdata;
        if ((fidx_reg + 2'h1) < len_now) begin
          fidx_next = fidx_reg + 2'h1;
          state_next = CRG_ST_FETCH;
        end else begin
          fidx_next = 2'h0;
          state_next = CRG_ST_EXEC;
        end
      end
      CRG_ST_EXEC: begin
        step_next = 2'h0;
        state_next = (nsteps_w != 3'h0) ? CRG_ST_ACC : CRG_ST_WAIT;
        if (is_incdec_b && !dst_mem) begin
          regs_next[dst_w] = alu_link.res;
          flag_next = alu_link.flags;
        end
        if (is_incdec_p || is_pair_load) begin
          // pair ops leave flags alone
          if (rp_w == CRG_PAIR_SP) begin
            sp_next = is_pair_load ? direct_w : pair_step_w;
          end else begin
            regs_next[{rp_w, 1'b0}] = is_pair_load ? b3_reg : pair_step_w[15:8];
            regs_next[{rp_w, 1'b1}] = is_pair_load ? b2_reg : pair_step_w[7:0];
          end
        end
        if (is_mvi && !dst_mem) regs_next[dst_w] = b2_reg;
        if (is_mov && !dst_mem && !src_mem) regs_next[dst_w] = regs_reg[src_w];
        if ((is_alu_r && !src_mem) || is_alu_i) begin
          regs_next[CRG_REG_A] = alu_link.res;
          flag_next = alu_link.flags;
        end
        if (op_reg == CRG_OP_SWAP_DE) begin
          regs_next[CRG_REG_H] = regs_reg[CRG_REG_D];
          regs_next[CRG_REG_L] = regs_reg[CRG_REG_E];
          regs_next[CRG_REG_D] = regs_reg[CRG_REG_H];
          regs_next[CRG_REG_E] = regs_reg[CRG_REG_L];
        end
      end
      CRG_ST_ACC: begin
        addr_next = step_addr;
        rd_next = !step_wr;
        wr_next = step_wr;
        wdata_next = step_data;
        state_next = CRG_ST_CAP;
      end
      CRG_ST_CAP: begin
        if (is_incdec_b && step_reg == 2'h0) tmp_next = mem_rdata;
        if (is_incdec_b && step_reg == 2'h1) flag_next = alu_link.flags;
        if (is_mov && src_mem) regs_next[dst_w] = mem_rdata;
        if (is_alu_r && src_mem) begin
          regs_next[CRG_REG_A] = alu_link.res;
          flag_next = alu_link.flags;
        end
        if (is_load_hl) begin
          regs_next[step_reg[0] ? CRG_REG_H : CRG_REG_L] = mem_rdata;
        end
        if (is_swap_stack && step_reg == 2'h0) tmp_next = mem_rdata;
        if (is_swap_stack && step_reg == 2'h1) tmp2_next = mem_rdata;
        if (is_swap_stack && step_reg == 2'h3) begin
          regs_next[CRG_REG_L] = tmp_reg;
          regs_next[CRG_REG_H] = tmp2_reg;
        end
        if (is_call && step_reg == 2'h1) begin
          sp_next = sp_reg - 16'h0002;
          pc_next = direct_w;
        end
        step_next = step_reg + 2'h1;
        state_next = ({1'b0, step_reg} + 3'h1 == nsteps_w) ? CRG_ST_WAIT : CRG_ST_ACC;
      end
      CRG_ST_WAIT: begin
        if (cnt_reg >= (states_reg - 5'h01)) begin
          state_next = CRG_ST_FETCH;
          done_next = 1'b1;
        end
      end
      default: state_next = CRG_ST_FETCH;
    endcase
  end

  // state registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= CRG_ST_FETCH;
      for (int i = 0; i < 8; i++) regs_reg[i] <= CRG_REG_RESET;
      flag_reg <= CRG_FLAGS_RESET;
      pc_reg <= CRG_PC_RESET;
      sp_reg <= CRG_SP_RESET;
      op_reg <= 8'h00;
      b2_reg <= 8'h00;
      b3_reg <= 8'h00;
      tmp_reg <= 8'h00;
      tmp2_reg <= 8'h00;
      fidx_reg <= 2'h0;
      len_reg <= 2'h1;
      cnt_reg <= 5'h00;
      states_reg <= CRG_T_OTHER;
      step_reg <= 2'h0;
      addr_reg <= 16'h0000;
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      wdata_reg <= 8'h00;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      regs_reg <= regs_next;
      flag_reg <= flag_next;
      pc_reg <= pc_next;
      sp_reg <= sp_next;
      op_reg <= op_next;
      b2_reg <= b2_next;
      b3_reg <= b3_next;
      tmp_reg <= tmp_next;
      tmp2_reg <= tmp2_next;
      fidx_reg <= fidx_next;
      len_reg <= len_next;
      cnt_reg <= cnt_next;
      states_reg <= states_next;
      step_reg <= step_next;
      addr_reg <= addr_next;
      rd_reg <= rd_next;
      wr_reg <= wr_next;
      wdata_reg <= wdata_next;
      done_reg <= done_next;
    end
  end

  // outputs straight from flip-flops
  assign mem_addr = addr_reg;
  assign mem_rd = rd_reg;
  assign mem_wr = wr_reg;
  assign mem_wdata = wdata_reg;
  assign instr_done = done_reg;
  assign flags = flag_reg;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  wire logic op_seen = (state_reg == CRG_ST_FCAP) && (fidx_reg == 2'h0);

  sequence s_op(logic [7:0] code);
    op_seen && (mem_rdata == code);
  endsequence

  sequence s_byte2_seen;
    (state_reg == CRG_ST_FCAP) && (fidx_reg == 2'h1);
  endsequence

  a_add_reg_time: assert property (
    (op_seen && mem_rdata[7:3] == 5'b10000 && mem_rdata[2:0] != 3'h6) |-> ##3 fetch_start)
    else $error("add register form not 4 cycles");
  a_adc_mem_time: assert property (s_op(8'h8E) |-> ##6 fetch_start)
    else $error("add with carry memory form not 7 cycles");
  a_and_imm_time: assert property (s_op(8'hE6) |-> ##6 fetch_start)
    else $error("and immediate not 7 cycles");
  a_call_time: assert property (s_op(8'hCD) |-> ##16 fetch_start)
    else $error("call not 17 cycles");
  a_call_skip_time: assert property (
    (s_op(8'hDC) and !flag_reg[CRG_FLAG_CY]) |-> !fetch_start [*8] ##3 fetch_start)
    else $error("untaken call on carry not 11 cycles");
  a_swap_stack_sp: assert property (
    s_op(8'hE3) |-> ##17 (fetch_start && sp_reg == $past(sp_reg, 17)))
    else $error("stack top swap moved pointer or wrong length");
  a_pair_inc_hl: assert property (
    s_op(8'h23) |-> ##2 (hl_w == $past(hl_w, 2) + 16'h0001 && flag_reg == $past(flag_reg, 2)))
    else $error("pair increment wrong");
  a_pair_dec_hl: assert property (
    s_op(8'h2B) |-> ##2 (hl_w == $past(hl_w, 2) - 16'h0001))
    else $error("pair decrement wrong");
  a_swap_de: assert property (
    s_op(8'hEB) |-> ##2 (regs_reg[CRG_REG_H] == $past(regs_reg[CRG_REG_D], 2) &&
                         regs_reg[CRG_REG_E] == $past(regs_reg[CRG_REG_L], 2)))
    else $error("hl de swap wrong");
  a_store_reg_mem: assert property (
    s_op(8'h70) |-> ##3 (mem_wr && mem_addr == hl_w && mem_wdata == regs_reg[CRG_REG_B]))
    else $error("register to memory move wrong");
  a_imm_to_reg: assert property (
    s_op(8'h06) |-> ##2 s_byte2_seen ##2 (regs_reg[CRG_REG_B] == $past(mem_rdata, 2)))
    else $error("immediate byte move to register wrong");
  a_inc_reg_flags: assert property (
    s_op(8'h04) |-> ##2 (flag_reg[CRG_FLAG_Z] == (regs_reg[CRG_REG_B] == 8'h00) &&
                         regs_reg[CRG_REG_B] == $past(regs_reg[CRG_REG_B], 2) + 8'h01 &&
                         flag_reg[CRG_FLAG_CY] == $past(flag_reg[CRG_FLAG_CY], 2)))
    else $error("register increment flags wrong");
  a_inc_mem_write: assert property (
    s_op(8'h34) |-> ##5 (mem_wr && mem_wdata == $past(mem_rdata, 2) + 8'h01))
    else $error("memory increment wrong");
  a_dec_mem_write: assert property (
    s_op(8'h35) |-> ##5 (mem_wr && mem_wdata == $past(mem_rdata, 2) - 8'h01))
    else $error("memory decrement wrong");
  a_load_hl_addr: assert property (
    s_op(8'h2A) |-> ##7 (mem_rd && mem_addr == direct_w) ##2 (mem_rd && mem_addr == direct_w + 16'h0001))
    else $error("direct hl load addressing wrong");

endmodule // crg_core

// ### rtl/crg_pkg.sv
// shared constants, types and decode functions for the register-group core
package crg_pkg;

  // flag byte layout
  localparam int CRG_FLAG_S = 7;
  localparam int CRG_FLAG_Z = 6;
  localparam int CRG_FLAG_AC = 4;
  localparam int CRG_FLAG_P = 2;
  localparam int CRG_FLAG_ONE = 1;
  localparam int CRG_FLAG_CY = 0;

  // values after reset
  localparam logic [7:0] CRG_FLAGS_RESET = 8'h02;
  localparam logic [7:0] CRG_REG_RESET = 8'h00;
  localparam logic [15:0] CRG_PC_RESET = 16'h0000;
  localparam logic [15:0] CRG_SP_RESET = 16'h0000;

  // register codes inside an opcode
  localparam logic [2:0] CRG_REG_B = 3'h0;
  localparam logic [2:0] CRG_REG_D = 3'h2;
  localparam logic [2:0] CRG_REG_E = 3'h3;
  localparam logic [2:0] CRG_REG_H = 3'h4;
  localparam logic [2:0] CRG_REG_L = 3'h5;
  localparam logic [2:0] CRG_REG_MEM = 3'h6;
  localparam logic [2:0] CRG_REG_A = 3'h7;
  localparam logic [1:0] CRG_PAIR_SP = 2'h3;

  // whole opcodes
  localparam logic [7:0] CRG_OP_STORE_HL = 8'h22;
  localparam logic [7:0] CRG_OP_LOAD_HL = 8'h2A;
  localparam logic [7:0] CRG_OP_SWAP_DE = 8'hEB;
  localparam logic [7:0] CRG_OP_SWAP_STACK = 8'hE3;
  localparam logic [7:0] CRG_OP_CALL = 8'hCD;
  localparam logic [7:0] CRG_OP_CALL_CARRY = 8'hDC;
  localparam logic [7:0] CRG_OP_ADD_IMM = 8'hC6;
  localparam logic [7:0] CRG_OP_ADC_IMM = 8'hCE;
  localparam logic [7:0] CRG_OP_AND_IMM = 8'hE6;
  localparam logic [7:0] CRG_OP_HALT_SLOT = 8'h76;

  // clock cycles per instruction
  localparam logic [4:0] CRG_T_ALU_REG = 5'h04;
  localparam logic [4:0] CRG_T_ALU_MEM = 5'h07;
  localparam logic [4:0] CRG_T_INCDEC_REG = 5'h05;
  localparam logic [4:0] CRG_T_INCDEC_MEM = 5'h0A;
  localparam logic [4:0] CRG_T_PAIR = 5'h05;
  localparam logic [4:0] CRG_T_PAIR_LOAD = 5'h0A;
  localparam logic [4:0] CRG_T_DIRECT = 5'h10;
  localparam logic [4:0] CRG_T_MVI_REG = 5'h07;
  localparam logic [4:0] CRG_T_MVI_MEM = 5'h0A;
  localparam logic [4:0] CRG_T_MOV_REG = 5'h05;
  localparam logic [4:0] CRG_T_MOV_MEM = 5'h07;
  localparam logic [4:0] CRG_T_SWAP_DE = 5'h04;
  localparam logic [4:0] CRG_T_SWAP_STACK = 5'h12;
  localparam logic [4:0] CRG_T_CALL = 5'h11;
  localparam logic [4:0] CRG_T_CALL_SKIP = 5'h0B;
  localparam logic [4:0] CRG_T_OTHER = 5'h04;

  // alu operations; add, adc and and equal opcode bits 5:3
  typedef enum logic [2:0] {
    CRG_ALU_ADD = 3'b000,
    CRG_ALU_ADC = 3'b001,
    CRG_ALU_INC = 3'b010,
    CRG_ALU_DEC = 3'b011,
    CRG_ALU_AND = 3'b100
  } crg_alu_op_t;

  typedef enum logic [2:0] {
    CRG_ST_FETCH = 3'b000,
    CRG_ST_FCAP = 3'b001,
    CRG_ST_EXEC = 3'b010,
    CRG_ST_ACC = 3'b011,
    CRG_ST_CAP = 3'b100,
    CRG_ST_WAIT = 3'b101
  } crg_state_t;

  // instruction length in bytes
  function automatic logic [1:0] crg_instr_len(input logic [7:0] op);
    if ((op[7:6] == 2'b00 && op[3:0] == 4'h1) || op == CRG_OP_STORE_HL ||
        op == CRG_OP_LOAD_HL || op == CRG_OP_CALL || op == CRG_OP_CALL_CARRY) begin
      return 2'h3;
    end else if ((op[7:6] == 2'b00 && op[2:0] == 3'b110) || op == CRG_OP_ADD_IMM ||
                 op == CRG_OP_ADC_IMM || op == CRG_OP_AND_IMM) begin
      return 2'h2;
    end
    return 2'h1;
  endfunction

  // clock cycles for an opcode, given the carry flag
  function automatic logic [4:0] crg_instr_states(input logic [7:0] op, input logic cy);
    logic mem_src;
    logic mem_dst;
    mem_src = (op[2:0] == CRG_REG_MEM);
    mem_dst = (op[5:3] == CRG_REG_MEM);
    if (op[7:6] == 2'b10) return mem_src ? CRG_T_ALU_MEM : CRG_T_ALU_REG;
    if (op[7:6] == 2'b01) return (mem_src || mem_dst) ? CRG_T_MOV_MEM : CRG_T_MOV_REG;
    if (op[7:6] == 2'b00) begin
      if (op[2:1] == 2'b10) return mem_dst ? CRG_T_INCDEC_MEM : CRG_T_INCDEC_REG;
      if (op[2:0] == 3'b011) return CRG_T_PAIR;
      if (op[3:0] == 4'h1) return CRG_T_PAIR_LOAD;
      if (op[2:0] == 3'b110) return mem_dst ? CRG_T_MVI_MEM : CRG_T_MVI_REG;
      if (op == CRG_OP_STORE_HL || op == CRG_OP_LOAD_HL) return CRG_T_DIRECT;
      return CRG_T_OTHER;
    end
    if (op == CRG_OP_ADD_IMM || op == CRG_OP_ADC_IMM || op == CRG_OP_AND_IMM) begin
      return CRG_T_ALU_MEM;
    end
    if (op == CRG_OP_SWAP_DE) return CRG_T_SWAP_DE;
    if (op == CRG_OP_SWAP_STACK) return CRG_T_SWAP_STACK;
    if (op == CRG_OP_CALL) return CRG_T_CALL;
    if (op == CRG_OP_CALL_CARRY) return cy ? CRG_T_CALL : CRG_T_CALL_SKIP;
    return CRG_T_OTHER;
  endfunction

endpackage

// ### rtl/crg_alu_if.sv
// operand and result carrier between the core and its alu
interface crg_alu_if;
  import crg_pkg::*;
  crg_alu_op_t op;
  logic [7:0] a;
  logic [7:0] b;
  logic cin;
  logic [7:0] res;
  logic [7:0] flags;
  modport core (output op, output a, output b, output cin, input res, input flags);
  modport alu (input op, input a, input b, input cin, output res, output flags);
endinterface

// ### rtl/crg_alu.sv
// byte alu: add, add with carry, and, increment, decrement with flags
module crg_alu
  import crg_pkg::*;
(
  crg_alu_if.alu alu_bus
);

  logic [7:0] b_eff;
  logic c_eff;
  logic [4:0] low_sum;
  logic [8:0] full_sum;
  logic carry_out;
  logic aux_out;

  // increment and decrement share the adder with a constant operand
  assign b_eff = (alu_bus.op == CRG_ALU_INC) ? 8'h01 :
                 (alu_bus.op == CRG_ALU_DEC) ? 8'hFF : alu_bus.b;
  assign c_eff = (alu_bus.op == CRG_ALU_ADC) ? alu_bus.cin : 1'b0;
  assign low_sum = {1'b0, alu_bus.a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c_eff};
  assign full_sum = {1'b0, alu_bus.a} + {1'b0, b_eff} + {8'h00, c_eff};

  // result and flag sources
  assign alu_bus.res = (alu_bus.op == CRG_ALU_AND) ? (alu_bus.a & alu_bus.b) : full_sum[7:0];
  assign carry_out = (alu_bus.op == CRG_ALU_AND) ? 1'b0 :
                     (alu_bus.op == CRG_ALU_INC || alu_bus.op == CRG_ALU_DEC) ? alu_bus.cin :
                     full_sum[8];
  assign aux_out = (alu_bus.op == CRG_ALU_AND) ? (alu_bus.a[3] | alu_bus.b[3]) : low_sum[4];

  // flag byte assembly
  always_comb begin
    alu_bus.flags = 8'h00;
    alu_bus.flags[CRG_FLAG_S] = alu_bus.res[7];
    alu_bus.flags[CRG_FLAG_Z] = (alu_bus.res == 8'h00);
    alu_bus.flags[CRG_FLAG_AC] = aux_out;
    alu_bus.flags[CRG_FLAG_P] = ~^alu_bus.res;
    alu_bus.flags[CRG_FLAG_ONE] = 1'b1;
    alu_bus.flags[CRG_FLAG_CY] = carry_out;
  end

endmodule // crg_alu

// ### dv/crg_mem_model.sv
// byte-wide memory with asynchronous read, facing the core's memory port
module crg_mem_model (
  input wire logic clk_sys,
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  bit [7:0] mem [65536];
  logic [7:0] last_reg;
  // read data only while selected, otherwise the inverse of the last byte
  assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_reg;
  // write on the edge closing the strobe cycle
  always @(posedge clk_sys) begin
    if (mem_rd) last_reg <= mem[mem_addr];
    if (mem_wr) mem[mem_addr] <= mem_wdata;
  end
endmodule // crg_mem_model

// ### dv/cpu_register_group_ops_test.sv
// self-checking bench running a register-group program on the core
module cpu_register_group_ops_test;
  import crg_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, reset_n, mem_rd, mem_wr, instr_done;
  logic [7:0] mem_rdata, mem_wdata, flags;
  logic [15:0] mem_addr;
  int err_count, n_checks;
  // program image: pair load, moves, inc/dec, alu, direct store/load, swaps, call skip
  logic [7:0] prog [] = '{8'h21, 8'h00, 8'h01, 8'h06, 8'h7F, 8'h04, 8'h70, 8'h23, 8'h36,
    8'h01, 8'h35, 8'h34, 8'h2B, 8'h7E, 8'h4F, 8'h81, 8'hCE, 8'h05, 8'h8E, 8'hE6, 8'h0F,
    8'hA1, 8'h0D, 8'h22, 8'h00, 8'h02, 8'h11, 8'h34, 8'h12, 8'hEB, 8'h31, 8'h00, 8'h03,
    8'hE3, 8'h2A, 8'h00, 8'h02, 8'h71, 8'hDC, 8'h00, 8'h00, 8'h00};
  // expected cycles and flags after each instruction
  logic [7:0] cyc [26] = '{8'h0A, 8'h07, 8'h05, 8'h07, 8'h05, 8'h0A, 8'h0A, 8'h0A, 8'h05,
    8'h07, 8'h05, 8'h04, 8'h07, 8'h07, 8'h07, 8'h04, 8'h05, 8'h10, 8'h0A, 8'h04, 8'h0A,
    8'h12, 8'h10, 8'h07, 8'h0B, 8'h04};
  logic [7:0] flg [26] = '{8'h02, 8'h02, 8'h92, 8'h92, 8'h92, 8'h92, 8'h56, 8'h02, 8'h02,
    8'h02, 8'h02, 8'h47, 8'h06, 8'h82, 8'h16, 8'h46, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02,
    8'h02, 8'h02, 8'h02, 8'h02, 8'h02};
  crg_core crg_core_i (.clk_sys(clk_sys), .reset_n(reset_n), .mem_rdata(mem_rdata),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .instr_done(instr_done), .flags(flags));
  crg_mem_model crg_mem_model_i (.clk_sys(clk_sys), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  // 50 ns clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // cycles up to the next instruction-end pulse, bounded
  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (instr_done !== 1'b1 && n < 100);
    if (n >= 100) begin
      err_count++;
      $display("ERROR %0t no instruction end seen", $time);
      complete_run();
    end
  endtask
  initial begin
    int n;
    err_count = 0;
    n_checks = 0;
    reset_n = 1'b0;
    foreach (prog[i]) crg_mem_model_i.mem[i] = prog[i];
    crg_mem_model_i.mem[16'h0300] = 8'hAA;
    crg_mem_model_i.mem[16'h0301] = 8'hBB;
    repeat (12) @(negedge clk_sys);
    reset_n = 1'b1;
    // flags of every instruction in turn, timing of every one after the first
    for (int k = 1; k <= 26; k++) begin
      wait_done(n);
      if (k > 1) check8(8'(n), cyc[k-1], "cycles");
      check8(flags, flg[k-1], "flags");
    end
    $display("test program done");
    // memory left behind by stores and swaps
    check8(crg_mem_model_i.mem[16'h0100], 8'h7F, "byte at 0100");
    check8(crg_mem_model_i.mem[16'h0101], 8'h01, "byte at 0101");
    check8(crg_mem_model_i.mem[16'h0200], 8'h00, "byte at 0200");
    check8(crg_mem_model_i.mem[16'h0201], 8'h01, "byte at 0201");
    check8(crg_mem_model_i.mem[16'h0300], 8'h34, "byte at 0300");
    check8(crg_mem_model_i.mem[16'h0301], 8'h12, "byte at 0301");
    $display("test memory done");
    complete_run();
  end
endmodule // cpu_register_group_ops_test
